// ---- rtl/aic_pkg.sv ----
// Shared constants and types of the converter control and readout block.
package aic_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_HZ = 25_000_000;
  // Nominal conversion rates in samples per second.
  localparam int SPS_R0 = 240;
  localparam int SPS_R1 = 60;
  localparam int SPS_R2 = 30;
  localparam int SPS_R3 = 15;
  // Conversion period in core clock cycles for each rate code.
  localparam int CYC_R0 = CLK_HZ / SPS_R0;
  localparam int CYC_R1 = CLK_HZ / SPS_R1;
  localparam int CYC_R2 = CLK_HZ / SPS_R2;
  localparam int CYC_R3 = CLK_HZ / SPS_R3;
  localparam int CNT_W = 21;

  // ****************************************
  // Result layout
  // ****************************************
  localparam int RES_W = 16;
  localparam int RES_R0 = 12;
  localparam int RES_R1 = 14;
  localparam int RES_R2 = 15;

  // ****************************************
  // Configuration register
  // ****************************************
  typedef struct packed {
    logic newDataFlag;
    logic [1:0] pad;
    logic singleShotSelect;
    logic [1:0] rateSelect;
    logic [1:0] gainSelect;
  } aic_cfg_t;
  localparam aic_cfg_t CFG_RST = 8'h8c;
  localparam logic [7:0] CFG_WR_MASK = 8'h1f;

  // ****************************************
  // Serial link
  // ****************************************
  localparam logic [6:0] GCALL_ADDR = 7'h00;
  localparam logic [7:0] GCALL_RESET = 8'h06;
  localparam logic [7:0] FILL_BYTE = 8'hff;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [3:0] FRAME_END = 4'h9;
  localparam logic [1:0] BYTE_HI = 2'h0;
  localparam logic [1:0] BYTE_LO = 2'h1;
  localparam logic [1:0] BYTE_CFG = 2'h2;
  localparam logic [1:0] BYTE_OVER = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADDR = 2'b01,
    ST_RXD = 2'b11,
    ST_TXD = 2'b10
  } aic_state_t;

  typedef enum logic [1:0] {
    EVT_NONE = 2'b00,
    EVT_WRITE = 2'b01,
    EVT_READ = 2'b10,
    EVT_GRST = 2'b11
  } aic_evt_t;

  // Event from the link side to the core side.
  typedef struct packed {
    aic_evt_t kind;
    logic [7:0] data;
  } aic_evt_msg_t;

  // Coherent snapshot from the core side to the link side.
  typedef struct packed {
    logic [15:0] result;
    aic_cfg_t cfg;
  } aic_status_t;

endpackage

// ---- rtl/aic_sync.sv ----
// Two flip-flop level synchroniser.
`timescale 1ns/1ps
module aic_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Data
  input wire logic [W-1:0] dIn,
  output logic [W-1:0] qOut
);

  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;

  // The first stage feeds only the second stage.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      stable_q <= '0;
    end else begin
      meta_q <= dIn;
      stable_q <= meta_q;
    end
  end

  assign qOut = stable_q;

endmodule // aic_sync

// ---- rtl/aic_xfer.sv ----
// Toggle handshake that carries one word between two clock domains.
`timescale 1ns/1ps
module aic_xfer #(
  parameter int W = 8
) (
  // Reset
  input wire logic arst_n,
  // Source side
  input wire logic srcClk,
  input wire logic srcSend,
  input wire logic [W-1:0] srcData,
  output logic srcBusy,
  // Destination side
  input wire logic dstClk,
  output logic dstValid,
  output logic [W-1:0] dstData
);

  logic reqTog_q;
  logic seenTog_q;
  logic dstValid_q;
  logic [W-1:0] hold_q;
  logic [W-1:0] dstData_q;
  logic reqSync;
  logic ackSync;
  logic newReq;

  // The held word stays still until the far side has answered.
  always_ff @(posedge srcClk or negedge arst_n) begin
    if (!arst_n) begin
      reqTog_q <= 1'b0;
      hold_q <= '0;
    end else if (srcSend && !srcBusy) begin
      reqTog_q <= ~reqTog_q;
      hold_q <= srcData;
    end
  end

  aic_sync #(.W(1)) uReqSync (
    .clk(dstClk),
    .arst_n(arst_n),
    .dIn(reqTog_q),
    .qOut(reqSync)
  );

  assign newReq = reqSync != seenTog_q;

  // Capture on a toggle; the word has been stable for two edges.
  always_ff @(posedge dstClk or negedge arst_n) begin
    if (!arst_n) begin
      seenTog_q <= 1'b0;
      dstValid_q <= 1'b0;
      dstData_q <= '0;
    end else begin
      dstValid_q <= newReq;
      if (newReq) begin
        seenTog_q <= reqSync;
        dstData_q <= hold_q;
      end
    end
  end

  aic_sync #(.W(1)) uAckSync (
    .clk(srcClk),
    .arst_n(arst_n),
    .dIn(seenTog_q),
    .qOut(ackSync)
  );

  assign srcBusy = reqTog_q != ackSync;
  assign dstValid = dstValid_q;
  assign dstData = dstData_q;

endmodule // aic_xfer

// ---- rtl/aic_top.sv ----
// Converter control, result register and serial slave link.
`timescale 1ns/1ps
module aic_top import aic_pkg::*; #(
  parameter logic [6:0] DEV_ADDR = 7'h20,
  parameter int CONV_CYC_R0 = CYC_R0,
  parameter int CONV_CYC_R1 = CYC_R1,
  parameter int CONV_CYC_R2 = CYC_R2,
  parameter int CONV_CYC_R3 = CYC_R3
) (
  // Core clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // Link sampling clock
  input wire logic i2cClk,
  // Serial pins; the clock pin is an input only
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Converter core
  input wire logic [15:0] modData,
  output logic convActive,
  output logic [1:0] rateSelect,
  output logic [1:0] gainSelect
);

  // ****************************************
  // Helpers
  // ****************************************

  // Sign-extend the result down to the resolution of the rate code.
  function automatic logic [15:0] fitRes(input logic [15:0] raw,
                                         input logic [1:0] rate);
    logic signed [15:0] s;
    s = $signed(raw);
    case (rate)
      2'h0: fitRes = 16'(s >>> (RES_W - RES_R0));
      2'h1: fitRes = 16'(s >>> (RES_W - RES_R1));
      2'h2: fitRes = 16'(s >>> (RES_W - RES_R2));
      default: fitRes = raw;
    endcase
  endfunction

  // Byte sent at each position of a read.
  function automatic logic [7:0] txByte(input logic [1:0] idx,
                                        input aic_status_t st);
    case (idx)
      BYTE_HI: txByte = st.result[15:8];
      BYTE_LO: txByte = st.result[7:0];
      BYTE_CFG: txByte = st.cfg;
      default: txByte = FILL_BYTE;
    endcase
  endfunction

  // ****************************************
  // Core domain
  // ****************************************
  aic_cfg_t cfg_q;
  aic_cfg_t cfgBase;
  aic_cfg_t cfgD;
  aic_cfg_t wrCfg;
  aic_evt_msg_t evtRx;
  aic_status_t coreStat;
  logic evtValid;
  logic cfgWr;
  logic cfgRd;
  logic softRst;
  logic [15:0] result_q;
  logic [15:0] resultD;
  logic running_q;
  logic runD;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] convPeriod;
  logic done;
  logic ssEff;
  logic startReq;
  logic flagD;
  logic statBusy;

  // Decode events handed over from the link.
  assign cfgWr = evtValid && evtRx.kind == EVT_WRITE;
  assign cfgRd = evtValid && evtRx.kind == EVT_READ;
  assign softRst = evtValid && evtRx.kind == EVT_GRST;
  assign wrCfg = evtRx.data;

  // Period of one conversion for the active rate code.
  assign convPeriod = cfg_q.rateSelect == 2'h0 ? CNT_W'(CONV_CYC_R0) :
                      cfg_q.rateSelect == 2'h1 ? CNT_W'(CONV_CYC_R1) :
                      cfg_q.rateSelect == 2'h2 ? CNT_W'(CONV_CYC_R2) :
                      CNT_W'(CONV_CYC_R3);
  // Compare with >= so a switch to a shorter rate mid-conversion
  // ends at once instead of waiting for the counter to wrap.
  assign done = running_q && cnt_q >= convPeriod - CNT_W'(1);

  // Written bits land masked, so bits 6 and 5 always read zero.
  assign cfgBase = cfgWr ? aic_cfg_t'(wrCfg & CFG_WR_MASK) : cfg_q;
  assign ssEff = cfgBase.singleShotSelect;
  // A start only counts when idle; a start written during a conversion is lost.
  assign startReq = cfgWr && wrCfg.singleShotSelect &&
                    wrCfg.newDataFlag && !running_q;

  // A finished conversion beats a config read in the same cycle.
  assign flagD = softRst ? CFG_RST.newDataFlag :
                 done ? 1'b0 :
                 (startReq || cfgRd) ? 1'b1 :
                 cfg_q.newDataFlag;
  assign cfgD = softRst ? CFG_RST : {flagD, cfgBase[6:0]};

  // Continuous mode restarts; single mode stops after its result.
  assign runD = softRst ? 1'b1 :
                done ? !ssEff :
                (running_q || !ssEff || startReq);

  // Only a finished conversion or a reset changes the result.
  assign resultD = softRst ? 16'h0000 :
                   done ? fitRes(modData, cfg_q.rateSelect) :
                   result_q;

  // Configuration register.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= CFG_RST;
    end else begin
      cfg_q <= cfgD;
    end
  end

  // Conversion sequencer and output register.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      running_q <= 1'b1;
      cnt_q <= '0;
      result_q <= 16'h0000;
    end else begin
      running_q <= runD;
      cnt_q <= (softRst || done || !running_q) ? '0 : cnt_q + CNT_W'(1);
      result_q <= resultD;
    end
  end

  assign convActive = running_q;
  assign rateSelect = cfg_q.rateSelect;
  assign gainSelect = cfg_q.gainSelect;
  // Result and flag travel together so the flag describes the result.
  assign coreStat = '{result: result_q, cfg: cfg_q};

  // ****************************************
  // Domain crossings
  // ****************************************
  aic_status_t linkStat;
  aic_evt_msg_t evtMsg_q;
  logic evtSend_q;
  logic statValid;

  // The snapshot is refreshed whenever the handshake is free.
  aic_xfer #(.W($bits(aic_status_t))) uStatXfer (
    .arst_n(arst_n),
    .srcClk(core_clk),
    .srcSend(1'b1),
    .srcData(coreStat),
    .srcBusy(statBusy),
    .dstClk(i2cClk),
    .dstValid(statValid),
    .dstData(linkStat)
  );

  aic_xfer #(.W($bits(aic_evt_msg_t))) uEvtXfer (
    .arst_n(arst_n),
    .srcClk(i2cClk),
    .srcSend(evtSend_q),
    .srcData(evtMsg_q),
    .srcBusy(),
    .dstClk(core_clk),
    .dstValid(evtValid),
    .dstData(evtRx)
  );

  // ****************************************
  // Link domain
  // ****************************************
  aic_state_t state_q;
  aic_status_t snap_q;
  logic [1:0] pinSync;
  logic sclS;
  logic sdaS;
  logic sclP_q;
  logic sdaP_q;
  logic sclRise;
  logic sclFall;
  logic startC;
  logic stopC;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [1:0] byteIdx_q;
  logic [1:0] idxNext;
  logic isRead_q;
  logic isGc_q;
  logic nack_q;
  logic sdaOe_q;
  logic gcHit;
  logic addrHit;

  // The clock pin is only sampled, never driven.
  aic_sync #(.W(2)) uPinSync (
    .clk(i2cClk),
    .arst_n(arst_n),
    .dIn({sclIn, sdaIn}),
    .qOut(pinSync)
  );
  assign sclS = pinSync[1];
  assign sdaS = pinSync[0];

  // Bus edges and conditions from the synchronised pins.
  assign sclRise = sclS && !sclP_q;
  assign sclFall = !sclS && sclP_q;
  assign startC = sclS && sclP_q && sdaP_q && !sdaS;
  assign stopC = sclS && sclP_q && !sdaP_q && sdaS;
  assign gcHit = shift_q[7:1] == GCALL_ADDR && !shift_q[0];
  assign addrHit = shift_q[7:1] == DEV_ADDR || gcHit;
  assign idxNext = byteIdx_q == BYTE_OVER ? BYTE_OVER : byteIdx_q + 2'h1;

  always_ff @(posedge i2cClk or negedge arst_n) begin
    if (!arst_n) begin
      sclP_q <= 1'b1;
      sdaP_q <= 1'b1;
    end else begin
      sclP_q <= sclS;
      sdaP_q <= sdaS;
    end
  end

  // Slave sequencer: bits move on the clock's rise, drive on its fall.
  always_ff @(posedge i2cClk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= ST_IDLE;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      byteIdx_q <= BYTE_HI;
      isRead_q <= 1'b0;
      isGc_q <= 1'b0;
      nack_q <= 1'b0;
      sdaOe_q <= 1'b0;
      snap_q <= '0;
      evtSend_q <= 1'b0;
      evtMsg_q <= '0;
    end else begin
      evtSend_q <= 1'b0;
      if (startC) begin
        state_q <= ST_ADDR;
        bitCnt_q <= 4'h0;
        byteIdx_q <= BYTE_HI;
        sdaOe_q <= 1'b0;
      end else if (stopC) begin
        state_q <= ST_IDLE;
        sdaOe_q <= 1'b0;
      end else if (sclRise && state_q != ST_IDLE) begin
        bitCnt_q <= bitCnt_q + 4'h1;
        if (bitCnt_q < ACK_SLOT) begin
          shift_q <= {shift_q[6:0], sdaS};
        end else if (state_q == ST_TXD) begin
          nack_q <= sdaS;
        end
      end else if (sclFall) begin
        case (state_q)
          ST_ADDR: begin
            if (bitCnt_q == ACK_SLOT) begin
              if (addrHit) begin
                sdaOe_q <= 1'b1;
                isRead_q <= shift_q[0];
                isGc_q <= gcHit;
                snap_q <= linkStat;
              end else begin
                state_q <= ST_IDLE;
              end
            end else if (bitCnt_q == FRAME_END) begin
              bitCnt_q <= 4'h0;
              nack_q <= 1'b0;
              if (isRead_q) begin
                state_q <= ST_TXD;
                shift_q <= txByte(BYTE_HI, snap_q);
                sdaOe_q <= !txByte(BYTE_HI, snap_q)[7];
              end else begin
                state_q <= ST_RXD;
                sdaOe_q <= 1'b0;
              end
            end
          end
          ST_RXD: begin
            if (bitCnt_q == ACK_SLOT) begin
              sdaOe_q <= byteIdx_q == BYTE_HI;
              byteIdx_q <= idxNext;
              // A general call only acts on its reset byte.
              evtSend_q <= byteIdx_q == BYTE_HI &&
                           (!isGc_q || shift_q == GCALL_RESET);
              evtMsg_q <= '{kind: isGc_q ? EVT_GRST : EVT_WRITE,
                            data: shift_q};
            end else if (bitCnt_q == FRAME_END) begin
              bitCnt_q <= 4'h0;
              sdaOe_q <= 1'b0;
            end
          end
          ST_TXD: begin
            if (bitCnt_q == ACK_SLOT) begin
              sdaOe_q <= 1'b0;
              evtSend_q <= byteIdx_q == BYTE_CFG;
              evtMsg_q <= '{kind: EVT_READ, data: 8'h00};
            end else if (bitCnt_q == FRAME_END) begin
              bitCnt_q <= 4'h0;
              if (nack_q) begin
                state_q <= ST_IDLE;
              end else begin
                byteIdx_q <= idxNext;
                shift_q <= txByte(idxNext, snap_q);
                sdaOe_q <= !txByte(idxNext, snap_q)[7];
              end
            end else if (bitCnt_q != 4'h0) begin
              sdaOe_q <= !shift_q[7];
            end
          end
          default: begin
            sdaOe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // Open drain: the line is only ever pulled low.
  assign sdaOut = 1'b0;
  assign sdaOe = sdaOe_q;

  // ****************************************
  // Assertions
  // ****************************************
  AST_FLAG_CLEAR: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    done && !softRst |=> !cfg_q.newDataFlag)
    else $error("flag not cleared by new result");

  AST_FLAG_SET_READ: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    cfgRd && !done |=> cfg_q.newDataFlag)
    else $error("flag not set after config read");

  AST_SINGLE_STOPS: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    done && cfg_q.singleShotSelect && !cfgWr && !softRst
    |=> !running_q ##1 !running_q)
    else $error("single conversion did not stop");

  AST_START_SINGLE: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    startReq && !softRst |=> running_q && cfg_q.newDataFlag)
    else $error("single conversion did not start");

  AST_RESULT_HOLD: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    !done && !softRst |=> $stable(result_q))
    else $error("result changed without a conversion");

  AST_GC_RESET: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    softRst |=> cfg_q == CFG_RST && result_q == 16'h0000)
    else $error("general call reset not applied");

  AST_CFG_WRITE: assert property (
    @(posedge core_clk) disable iff (!arst_n)
    cfgWr |=> cfg_q[6:0] == $past(wrCfg[6:0] & CFG_WR_MASK[6:0]))
    else $error("config write not stored");

  AST_LATE_NOACK: assert property (
    @(posedge i2cClk) disable iff (!arst_n)
    state_q == ST_RXD && byteIdx_q >= BYTE_CFG |-> !sdaOe_q)
    else $error("byte after the first acknowledged");

  AST_HI_FIRST: assert property (
    @(posedge i2cClk) disable iff (!arst_n)
    state_q == ST_ADDR && isRead_q && sclFall && bitCnt_q == FRAME_END
    && !startC && !stopC |=> state_q == ST_TXD &&
    shift_q == snap_q.result[15:8])
    else $error("read did not start with upper result byte");

  AST_FILL_ONES: assert property (
    @(posedge i2cClk) disable iff (!arst_n)
    state_q == ST_TXD && byteIdx_q == BYTE_CFG && sclFall &&
    bitCnt_q == FRAME_END && !nack_q && !startC && !stopC
    |=> shift_q == FILL_BYTE)
    else $error("fourth byte not all ones");

  COV_SINGLE_DONE: cover property (
    @(posedge core_clk) disable iff (!arst_n)
    done && cfg_q.singleShotSelect);
  COV_CFG_READ: cover property (
    @(posedge core_clk) disable iff (!arst_n) cfgRd);
  COV_GC_RESET: cover property (
    @(posedge core_clk) disable iff (!arst_n) softRst);
  COV_OVER_READ: cover property (
    @(posedge i2cClk) disable iff (!arst_n)
    state_q == ST_TXD && byteIdx_q == BYTE_OVER);

endmodule // aic_top

// ---- verif/aic_i2c_master.sv ----
// Serial bus master model that drives the clock line and shares data.
`timescale 1ns/1ps
module aic_i2c_master (
  // Pacing clock
  input wire logic i2cClk,
  // Bus lines; sdaRel high lets the pull-up win the data line
  output logic scl,
  output logic sdaRel,
  input wire logic sda
);
  // ****************************************
  // Bit level
  // ****************************************
  // Both lines idle high so no false start is seen at time zero.
  initial begin
    scl = 1'b1;
    sdaRel = 1'b1;
  end

  // Every change lands just after a link clock edge.
  task automatic tick(input int n);
    repeat (n) @(posedge i2cClk);
  endtask

  // Data moves two edges after the clock fall, so the device never sees
  // data and clock change together; low time is 1.5 us, high 1 us.
  task automatic bit_slot(input logic b, output logic r);
    tick(2);
    sdaRel <= b;
    tick(10);
    scl <= 1'b1;
    tick(8);
    r = sda;
    scl <= 1'b0;
  endtask

  // ****************************************
  // Frame level
  // ****************************************
  // Data falls while the clock is high.
  task automatic start();
    sdaRel <= 1'b1;
    scl <= 1'b1;
    tick(8);
    sdaRel <= 1'b0;
    tick(8);
    scl <= 1'b0;
  endtask

  // Data rises while the clock is high, then the bus is left idle.
  task automatic stop();
    tick(2);
    sdaRel <= 1'b0;
    tick(10);
    scl <= 1'b1;
    tick(8);
    sdaRel <= 1'b1;
    tick(8);
  endtask

  // Sends eight bits, then releases the line for the device's ack.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(d[i], r);
    end
    bit_slot(1'b1, r);
    ack = ~r;
  endtask

  // Reads eight bits; a nack on the last byte ends the read early.
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_slot(1'b1, r);
      d[i] = r;
    end
    bit_slot(last, r);
  endtask
endmodule // aic_i2c_master

// ---- verif/testbench.sv ----
// Self-checking bench for the converter control and serial link block.
`timescale 1ns/1ps
`define CHK(n, e, g) begin \
  cmpCount++; \
  if ((g) !== (e)) begin \
    errCount++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); \
  end \
end
module testbench;
  import aic_pkg::*;
  // ****************************************
  // Signals and instances
  // ****************************************
  // Matches the design's default address, so no override is needed.
  localparam logic [6:0] ADR = 7'h20;
  logic core_clk = 1'b0;
  logic i2cClk = 1'b0;
  logic arst_n = 1'b0;
  logic [15:0] modData = 16'h0000;
  wire scl;
  wire sdaRel;
  logic sdaOut;
  logic sdaOe;
  logic convActive;
  logic [1:0] rateSelect;
  logic [1:0] gainSelect;
  int errCount = 0;
  int cmpCount = 0;
  logic [7:0] rb [0:3];
  logic ack;
  // Open-drain data line with a pull-up.
  wire sdaWire = sdaRel & ~(sdaOe & ~sdaOut);

  // Core clock at 25 MHz; link clock at 8 MHz with its own phase.
  always #20 core_clk = ~core_clk;
  initial begin
    #7;
    forever #62.5 i2cClk = ~i2cClk;
  end

  aic_i2c_master u_mst (.i2cClk, .scl, .sdaRel, .sda(sdaWire));

  // Short conversion periods keep the run brief.
  aic_top #(.CONV_CYC_R0(2000), .CONV_CYC_R2(4000),
    .CONV_CYC_R3(5000)) u_dut (.core_clk, .arst_n,
    .i2cClk, .sclIn(scl), .sdaIn(sdaWire), .sdaOut, .sdaOe, .modData,
    .convActive, .rateSelect, .gainSelect);

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic close_out();
    $display("Compares %0d, mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic rd(input int n);
    u_mst.start();
    u_mst.wr_byte({ADR, 1'b1}, ack);
    `CHK("read addr ack", 1'b1, ack)
    for (int i = 0; i < n; i++) begin
      u_mst.rd_byte(i == n - 1, rb[i]);
    end
    u_mst.stop();
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d,
    input logic expAck);
    u_mst.start();
    u_mst.wr_byte({a, 1'b0}, ack);
    `CHK("write addr ack", expAck, ack)
    if (ack) begin
      u_mst.wr_byte(d, ack);
      `CHK("data ack", 1'b1, ack)
    end
    u_mst.stop();
    u_mst.tick(20);
  endtask

  task automatic chk3(input logic [15:0] res, input logic [7:0] cfg);
    rd(3);
    `CHK("result hi", res[15:8], rb[0])
    `CHK("result lo", res[7:0], rb[1])
    `CHK("config", cfg, rb[2])
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 20000 && convActive !== 1'b0; i++) begin
      @(posedge core_clk);
    end
    `CHK("conv idle", 1'b0, convActive)
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    `CHK("rate", 2'b11, rateSelect)
    `CHK("gain", 2'b00, gainSelect)
    rd(4);
    `CHK("res hi", 8'h00, rb[0])
    `CHK("res lo", 8'h00, rb[1])
    `CHK("cfg", 8'h8c, rb[2])
    `CHK("fill", 8'hff, rb[3])
  endtask

  // Single shot at the fastest rate; the extra byte must be refused.
  task automatic t_single();
    @(posedge core_clk) modData <= 16'h8a50;
    u_mst.start();
    u_mst.wr_byte({ADR, 1'b0}, ack);
    u_mst.wr_byte(8'h13, ack);
    `CHK("first ack", 1'b1, ack)
    u_mst.wr_byte(8'h55, ack);
    `CHK("extra ack", 1'b0, ack)
    u_mst.stop();
    u_mst.tick(20);
    `CHK("rate", 2'b00, rateSelect)
    `CHK("gain", 2'b11, gainSelect)
    wait_idle();
    chk3(16'hf8a5, 8'h13);
    chk3(16'hf8a5, 8'h93);
  endtask

  // Writing the flag starts one conversion; old data stays meanwhile.
  task automatic t_trigger();
    @(posedge core_clk) modData <= 16'h7ff0;
    wr(ADR, 8'h99, 1'b1);
    chk3(16'hf8a5, 8'h99);
    `CHK("running", 1'b1, convActive)
    wait_idle();
    chk3(16'h3ff8, 8'h19);
  endtask

  // A foreign address is ignored; a one-byte read is accepted.
  task automatic t_addr();
    wr(ADR ^ 7'h01, 8'h00, 1'b0);
    `CHK("gain kept", 2'b01, gainSelect)
    rd(1);
    `CHK("short read", 8'h3f, rb[0])
    chk3(16'h3ff8, 8'h99);
  endtask

  task automatic t_gcall();
    wr(GCALL_ADDR, GCALL_RESET, 1'b1);
    u_mst.tick(40);
    `CHK("rate", 2'b11, rateSelect)
    `CHK("gain", 2'b00, gainSelect)
    chk3(16'h0000, 8'h8c);
  endtask

  // ****************************************
  // Main sequence and watchdog
  // ****************************************
  // Reset spans three core cycles and at least two link clock edges.
  initial begin
    repeat (3) @(posedge core_clk);
    repeat (2) @(posedge i2cClk);
    @(posedge core_clk) arst_n <= 1'b1;
    u_mst.tick(10);
    t_reset();
    t_single();
    t_trigger();
    t_addr();
    t_gcall();
    close_out();
  end

  // The sequence needs about 1 ms; four times that means a hang.
  initial begin
    #4_000_000;
    errCount++;
    close_out();
  end
endmodule // testbench
